// ### dv/smart_data_report_responder_tb.sv
// self-checking bench for the reliability report responder
`default_nettype none
module smart_data_report_responder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smart_pkg::*;
  logic        core_clk, arst_n, cmd_valid, smart_enabled, intrq_clr;
  logic        upd_valid, slow, bsy, drq, intrq, err, abrt, cyl_we;
  logic        data_valid, data_read, nv_req, nv_fetch, nv_ack;
  logic [7:0]  cmd_code, features, cyl_lo_in, cyl_hi_in, upd_value;
  logic [7:0]  cyl_lo_out, cyl_hi_out;
  logic [4:0]  upd_slot;
  logic [15:0] data_word;
  logic [7:0]  got [512];
  logic [7:0]  want [512];
  logic [7:0]  vals [4];
  logic [7:0]  lv [4] = '{8'h14, 8'h24, 8'h10, 8'h00};
  logic [7:0]  bf [8] = '{8'hd2, 8'hd3, 8'hd8, 8'hd9, 8'hd4, 8'hd0,
                          8'hd1, 8'hda};
  int          num_errors, total_checks, nbytes, cycles;
  smart_report_responder #(.CAP_PRE_POWER(1'b1), .CAP_AUTOSAVE(1'b0)) dut (
    .core_clk, .arst_n, .cmd_valid, .cmd_code, .features, .cyl_lo_in,
    .cyl_hi_in, .smart_enabled, .intrq_clr, .bsy, .drq, .intrq, .err,
    .abrt, .cyl_we, .cyl_lo_out, .cyl_hi_out, .data_word, .data_valid,
    .data_read, .nv_req, .nv_fetch, .nv_ack, .upd_valid, .upd_slot,
    .upd_value);
  smart_host_model host (.core_clk, .arst_n, .nv_req, .data_valid, .slow,
    .nv_ack, .data_read);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // capture words the host takes; a hang ends the run as a failure
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
    if (data_read === 1'b1 && data_valid === 1'b1 && nbytes < 511) begin
      got[nbytes] = data_word[7:0];
      got[nbytes + 1] = data_word[15:8];
      nbytes += 2;
    end
  end
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic issue(input logic [7:0] c, input logic [7:0] f,
                       input logic [7:0] lo, input logic [7:0] hi,
                       input logic en);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    features = f;
    cyl_lo_in = lo;
    cyl_hi_in = hi;
    smart_enabled = en;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((bsy !== 1'b0 || drq !== 1'b0) && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    check(16'(n < 3000), 16'h0001);
  endtask
  // expected block: entries, capability word and trailing checksum
  function automatic void build(input logic thr);
    logic [7:0] sum;
    logic [7:0] ids [4] = '{8'h01, 8'h05, 8'h09, 8'hc2};
    sum = 8'h00;
    foreach (want[i]) want[i] = 8'h00;
    want[0] = 8'h04;
    for (int s = 0; s < 4; s++) begin
      want[2 + 12 * s] = ids[s];
      want[3 + 12 * s] = thr ? lv[s] : ((s < 2) ? 8'h01 : 8'h00);
      if (!thr) want[5 + 12 * s] = vals[s];
    end
    if (!thr) want[368] = 8'h01;
    for (int i = 0; i < 511; i++) sum += want[i];
    want[511] = 8'h00 - sum;
  endfunction
  task automatic upd(input logic [4:0] s, input logic [7:0] v);
    @(negedge core_clk);
    upd_valid = 1'b1;
    upd_slot = s;
    upd_value = v;
    if (s < 4) vals[s[1:0]] = (v == 8'h00 || v == 8'hff) ? 8'hfe : v;
    @(negedge core_clk);
    upd_valid = 1'b0;
  endtask
  task automatic do_read(input logic [7:0] f, input logic slw,
                         input logic intr);
    slow = slw;
    nbytes = 0;
    issue(CMD_SMART, f, SIG_LO, SIG_HI, 1'b1);
    check(16'(bsy), 16'h0001);
    if (intr) begin
      repeat (60) if (drq !== 1'b1) @(negedge core_clk);
      issue(CMD_SMART, FEAT_VERDICT, SIG_LO, SIG_HI, 1'b1);
      check({bsy, cyl_we}, 16'h0000);
    end
    wait_idle();
    build(f == FEAT_THRESH);
    check(16'(nbytes), 16'h0200);
    for (int i = 0; i < 512; i++) check(got[i], want[i]);
    check(16'(intrq), 16'h0001);
    @(negedge core_clk);
    intrq_clr = 1'b1;
    @(negedge core_clk);
    intrq_clr = 1'b0;
    check(16'(intrq), 16'h0000);
  endtask
  task automatic verdict();
    logic fail;
    int n;
    fail = 1'b0;
    n = 0;
    for (int s = 0; s < 4; s++) begin
      if (vals[s] != 8'hfe && vals[s] <= lv[s]) fail = 1'b1;
    end
    issue(CMD_SMART, FEAT_VERDICT, SIG_LO, SIG_HI, 1'b1);
    while (cyl_we !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    check({cyl_lo_out, cyl_hi_out}, fail ? 16'hf42c : 16'h4fc2);
    @(negedge core_clk);
    check({bsy, intrq, err, abrt}, 16'h0004);
  endtask
  initial begin
    void'($urandom(60));
    {arst_n, cmd_valid, smart_enabled, intrq_clr, upd_valid, slow} = '0;
    {cmd_code, features, cyl_lo_in, cyl_hi_in, upd_value, upd_slot} = '0;
    foreach (vals[i]) vals[i] = 8'h64;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    check({bsy, drq, intrq, err, abrt, cyl_we, data_valid, nv_req},
          16'h0000);
    do_read(FEAT_THRESH, 1'b0, 1'b0);
    do_read(FEAT_VALUES, 1'b1, 1'b1);
    $display("test reads done");
    upd(5'h01, 8'h25);
    verdict();
    upd(5'h01, 8'h24);
    verdict();
    upd(5'h00, 8'h00);
    upd(5'h02, 8'hff);
    upd(5'h1f, 8'h01);
    do_read(FEAT_VALUES, 1'b0, 1'b0);
    $display("test boundary done");
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 4; s++) upd(5'(s), 8'($urandom_range(1, 253)));
      do_read(r[0] ? FEAT_THRESH : FEAT_VALUES, r[1], 1'b0);
      verdict();
    end
    $display("test random done");
    // reset in mid-stream: outputs clear and values return to 64h
    slow = 1'b1;
    issue(CMD_SMART, FEAT_VALUES, SIG_LO, SIG_HI, 1'b1);
    repeat (40) @(negedge core_clk);
    arst_n = 1'b0;
    foreach (vals[i]) vals[i] = 8'h64;
    @(negedge core_clk);
    arst_n = 1'b1;
    check({bsy, drq, intrq, err, abrt, cyl_we, data_valid, nv_req},
          16'h0000);
    do_read(FEAT_VALUES, 1'b0, 1'b0);
    $display("test reset done");
    // unknown subcommands, wrong signatures and a disabled feature
    for (int i = 0; i < 8; i++) begin
      issue(CMD_SMART, bf[i], (i == 5) ? 8'h4e : SIG_LO,
            (i == 6) ? 8'hc3 : SIG_HI, i != 7);
      check(16'(bsy), 16'h0001);
      @(negedge core_clk);
      check({bsy, err, abrt, intrq}, 16'h0007);
      wait_idle();
    end
    verdict();
    issue(8'hec, FEAT_VERDICT, SIG_LO, SIG_HI, 1'b1);
    check(16'(bsy), 16'h0000);
    $display("test aborts done");
    conclude();
  end
endmodule
`default_nettype wire

// ### dv/smart_host_model.sv
// host side model: storage acknowledge and data register reader
`default_nettype none
module smart_host_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // storage step, data register and pacing
  input  wire logic nv_req,
  input  wire logic data_valid,
  input  wire logic slow,
  output logic      nv_ack,
  output logic      data_read
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  // one acknowledge per request, quick or after a long storage delay
  always @(negedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nv_ack <= 1'b0;
      wait_cnt <= 0;
    end else if (nv_ack) begin
      nv_ack <= 1'b0;
    end else if (nv_req) begin
      if (wait_cnt >= (slow ? 6 : 0)) begin
        nv_ack <= 1'b1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
  // whole words
  // a slow host stalls the data register, so the buffer must hold words
  always @(negedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_read <= 1'b0;
    end else begin
      // only ask for a word that is on offer
      data_read <= data_valid &&
                   (slow ? ($urandom_range(0, 2) == 0) : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ### dv/smart_report_checker.sv
// checker: port-level properties of the reliability report responder
`default_nettype none
module smart_report_checker
  import smart_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // command side
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [7:0]  features,
  input wire logic [7:0]  cyl_lo_in,
  input wire logic [7:0]  cyl_hi_in,
  input wire logic        smart_enabled,
  input wire logic        intrq_clr,
  // status and results
  input wire logic        bsy,
  input wire logic        drq,
  input wire logic        intrq,
  input wire logic        err,
  input wire logic        abrt,
  input wire logic        cyl_we,
  input wire logic [7:0]  cyl_lo_out,
  input wire logic [7:0]  cyl_hi_out,
  // data and storage
  input wire logic [15:0] data_word,
  input wire logic        data_valid,
  input wire logic        data_read,
  input wire logic        nv_req,
  input wire logic        nv_fetch,
  input wire logic        nv_ack
);
  logic verdict_reg;
  logic take;
  logic good;
  // idle is exactly busy and data request both low, so no take is missed
  assign take = cmd_valid && cmd_code == CMD_SMART && !bsy && !drq;
  assign good = smart_enabled && cyl_lo_in == SIG_LO && cyl_hi_in == SIG_HI
    && (features == FEAT_VALUES || features == FEAT_THRESH
    || features == FEAT_VERDICT);
  // remember whether the running command is a verdict
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      verdict_reg <= 1'b0;
    end else if (take) begin
      verdict_reg <= features == FEAT_VERDICT;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_abort_end;
    !bsy && err && abrt && intrq;
  endsequence
  sequence s_stream_open;
    drq && !bsy && intrq && !nv_req;
  endsequence
  sequence s_verdict_end;
    cyl_we && bsy ##1 !bsy && intrq && !cyl_we;
  endsequence
  property p_abort;
    take && !good |=> bsy ##1 s_abort_end;
  endproperty
  a_abort: assert property (p_abort) else $error("abort walk wrong");
  property p_start;
    take && good |=> bsy && nv_req
      && nv_fetch == ($past(features) == FEAT_THRESH);
  endproperty
  a_start: assert property (p_start) else $error("start wrong");
  property p_open;
    nv_req && nv_ack && !verdict_reg |=> s_stream_open;
  endproperty
  a_open: assert property (p_open) else $error("stream open wrong");
  property p_verdict;
    nv_req && nv_ack && verdict_reg |=> s_verdict_end;
  endproperty
  a_verdict: assert property (p_verdict) else $error("verdict walk");
  property p_codes;
    cyl_we |-> (cyl_lo_out == SIG_LO && cyl_hi_out == SIG_HI)
      || (cyl_lo_out == FAIL_LO && cyl_hi_out == FAIL_HI);
  endproperty
  a_codes: assert property (p_codes) else $error("verdict code");
  property p_hold;
    data_valid && !data_read |=> data_valid && $stable(data_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word not held");
  property p_clr;
    intrq_clr && !bsy |=> !intrq;
  endproperty
  a_clr: assert property (p_clr) else $error("intrq not cleared");
  property p_drq;
    drq |-> !bsy;
  endproperty
  a_drq: assert property (p_drq) else $error("drq with busy");
endmodule
bind smart_report_responder smart_report_checker u_checker (
  .core_clk, .arst_n, .cmd_valid, .cmd_code, .features, .cyl_lo_in,
  .cyl_hi_in, .smart_enabled, .intrq_clr, .bsy, .drq, .intrq, .err, .abrt,
  .cyl_we, .cyl_lo_out, .cyl_hi_out, .data_word, .data_valid, .data_read,
  .nv_req, .nv_fetch, .nv_ack
);
`default_nettype wire

// ### rtl/attr_store.sv
// flip-flop store of the current attribute values, one byte per slot
`default_nettype none
module attr_store
  import smart_pkg::*;
#(
  parameter int NSLOT = 30
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  // update from the attribute monitor
  input  wire logic               upd_valid,
  input  wire logic [4:0]         upd_slot,
  input  wire logic [7:0]         upd_value,
  // all values, slot 0 in the low byte
  output logic [NSLOT*8-1:0]      values
);
  logic [7:0] val_reg [NSLOT];
  logic [7:0] upd_clean;

  // forbidden codes
  // 00h and ffh would be misread as test codes, so they turn into fe
  assign upd_clean = (upd_value == ATTR_NEVER_LO ||
                      upd_value == ATTR_NEVER_HI) ? ATTR_BAD : upd_value;

  for (genvar g = 0; g < NSLOT; g++) begin : g_slot
    // initial value
    // every slot starts at 64h until monitoring reports
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        val_reg[g] <= ATTR_INIT;
      end else if (upd_valid && upd_slot == 5'(g)) begin
        val_reg[g] <= upd_clean;
      end
    end
    assign values[g*8 +: 8] = val_reg[g];
  end
endmodule
`default_nettype wire

// ### rtl/smart_pkg.sv
// package: reliability report constants, layouts and factory thresholds
`default_nettype none
package smart_pkg;
  // task-file codes
  localparam logic [7:0] CMD_SMART    = 8'hb0;
  localparam logic [7:0] FEAT_VALUES  = 8'hd0;
  localparam logic [7:0] FEAT_THRESH  = 8'hd1;
  localparam logic [7:0] FEAT_VERDICT = 8'hda;
  localparam logic [7:0] SIG_LO       = 8'h4f;
  localparam logic [7:0] SIG_HI       = 8'hc2;
  localparam logic [7:0] FAIL_LO      = 8'hf4;
  localparam logic [7:0] FAIL_HI      = 8'h2c;
  // structure layout, byte offsets within the 512-byte block
  localparam int         SLOTS        = 30;
  localparam logic [8:0] OFS_ENTRY    = 9'h002;
  localparam logic [8:0] OFS_PAD      = 9'h16a;
  localparam logic [8:0] OFS_CAP      = 9'h170;
  localparam logic [8:0] OFS_LAST     = 9'h1fe;
  localparam logic [8:0] WORDS        = 9'h100;
  localparam logic [8:0] WORD_STEP    = 9'h001;
  localparam logic [3:0] POS_STEP     = 4'h2;
  localparam logic [3:0] POS_LAST     = 4'ha;
  localparam logic [3:0] POS_ID       = 4'h0;
  localparam logic [3:0] POS_THR      = 4'h1;
  localparam logic [3:0] POS_FLAG_LO  = 4'h1;
  localparam logic [3:0] POS_VALUE    = 4'h3;
  localparam logic [7:0] REV_LO       = 8'h04;
  localparam logic [7:0] REV_HI       = 8'h00;
  // attribute value codes
  localparam logic [7:0] ATTR_INIT    = 8'h64;
  localparam logic [7:0] ATTR_BAD     = 8'hfe;
  localparam logic [7:0] ATTR_NEVER_LO = 8'h00;
  localparam logic [7:0] ATTR_NEVER_HI = 8'hff;

  // factory identifiers, packed from slot 0 and shared by both structures
  function automatic logic [7:0] thr_id(input logic [4:0] s);
    case (s)
      5'h00:   thr_id = 8'h01;
      5'h01:   thr_id = 8'h05;
      5'h02:   thr_id = 8'h09;
      5'h03:   thr_id = 8'hc2;
      default: thr_id = 8'h00;
    endcase
  endfunction

  // fixed factory thresholds
  // factory thresholds; 00h always passes, fe never appears
  function automatic logic [7:0] thr_level(input logic [4:0] s);
    case (s)
      5'h00:   thr_level = 8'h14;
      5'h01:   thr_level = 8'h24;
      5'h02:   thr_level = 8'h10;
      default: thr_level = 8'h00;
    endcase
  endfunction

  // pre-failure class per slot
  function automatic logic thr_prefail(input logic [4:0] s);
    case (s)
      5'h00:   thr_prefail = 1'b1;
      5'h01:   thr_prefail = 1'b1;
      default: thr_prefail = 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### rtl/smart_report_responder.sv
// responder for the threshold, value and verdict reliability subcommands
`default_nettype none
module smart_report_responder
  import smart_pkg::*;
#(
  parameter logic CAP_PRE_POWER = 1'b0,
  parameter logic CAP_AUTOSAVE  = 1'b0
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // command from the task-file logic
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] features,
  input  wire logic [7:0] cyl_lo_in,
  input  wire logic [7:0] cyl_hi_in,
  input  wire logic       smart_enabled,
  input  wire logic       intrq_clr,
  // status and task-file results
  output logic            bsy,
  output logic            drq,
  output logic            intrq,
  output logic            err,
  output logic            abrt,
  output logic            cyl_we,
  output logic [7:0]      cyl_lo_out,
  output logic [7:0]      cyl_hi_out,
  // data register words
  output logic [15:0]     data_word,
  output logic            data_valid,
  input  wire logic       data_read,
  // non-volatile storage handshake
  output logic            nv_req,
  output logic            nv_fetch,
  input  wire logic       nv_ack,
  // attribute monitor
  input  wire logic       upd_valid,
  input  wire logic [4:0] upd_slot,
  input  wire logic [7:0] upd_value
);
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_NV      = 5'h02,
    ST_STREAM  = 5'h04,
    ST_VERDICT = 5'h08,
    ST_ABORT   = 5'h10
  } state_e;

  state_e            state_reg;
  logic              bsy_reg;
  logic              drq_reg;
  logic              intrq_reg;
  logic              err_reg;
  logic              abrt_reg;
  logic              cyl_we_reg;
  logic [7:0]        cyl_lo_reg;
  logic [7:0]        cyl_hi_reg;
  logic              nv_req_reg;
  logic              nv_fetch_reg;
  logic              op_thr_reg;
  logic              op_verdict_reg;
  logic [8:0]        word_reg;
  logic [4:0]        slot_reg;
  logic [3:0]        pos_reg;
  logic [7:0]        sum_reg;
  logic [SLOTS*8-1:0] vals;
  logic              take;
  logic              req_ok;
  logic              known;
  logic              exceeded;
  logic              gen_valid;
  logic              gen_ready;
  logic              push;
  logic              buf_empty;
  logic [8:0]        ofs;
  logic [7:0]        val_cur;
  logic [7:0]        lo_byte;
  logic [7:0]        hi_byte;

  // one byte of a 12-byte entry; unused slots are all zero
  function automatic logic [7:0] entry_byte(input logic       thr,
                                            input logic [4:0] s,
                                            input logic [3:0] p,
                                            input logic [7:0] v);
    entry_byte = 8'h00;
    if (thr_id(s) != 8'h00) begin
      case (p)
        POS_ID: entry_byte = thr_id(s);
        POS_THR: begin
          entry_byte = thr ? thr_level(s) : {7'h00, thr_prefail(s)};
        end
        POS_VALUE: entry_byte = thr ? 8'h00 : v;
        default:   entry_byte = 8'h00;
      endcase
    end
  endfunction

  attr_store #(
    .NSLOT (SLOTS)
  ) u_store (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .upd_valid (upd_valid),
    .upd_slot  (upd_slot),
    .upd_value (upd_value),
    .values    (vals)
  );

  // outputs come straight from their flops
  assign bsy        = bsy_reg;
  assign drq        = drq_reg;
  assign intrq      = intrq_reg;
  assign err        = err_reg;
  assign abrt       = abrt_reg;
  assign cyl_we     = cyl_we_reg;
  assign cyl_lo_out = cyl_lo_reg;
  assign cyl_hi_out = cyl_hi_reg;
  assign nv_req     = nv_req_reg;
  assign nv_fetch   = nv_fetch_reg;

  // command decode; other command codes belong to other handlers
  assign take  = (state_reg == ST_IDLE) && cmd_valid && cmd_code == CMD_SMART;
  assign known = features == FEAT_VALUES || features == FEAT_THRESH ||
                 features == FEAT_VERDICT;
  assign req_ok = known && smart_enabled &&
                  cyl_lo_in == SIG_LO && cyl_hi_in == SIG_HI;

  // threshold compare
  // an fe value carries no measurement and cannot fail
  always_comb begin
    exceeded = 1'b0;
    for (int s = 0; s < SLOTS; s++) begin
      if (thr_id(5'(s)) != 8'h00 && vals[s*8 +: 8] != ATTR_BAD &&
          vals[s*8 +: 8] <= thr_level(5'(s))) begin
        exceeded = 1'b1;
      end
    end
  end

  // main sequence
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            state_reg <= req_ok ? ST_NV : ST_ABORT;
          end
        end
        ST_NV: begin
          if (nv_ack) begin
            state_reg <= op_verdict_reg ? ST_VERDICT : ST_STREAM;
          end
        end
        ST_STREAM: begin
          // drq holds until the host has drained the last word
          if (word_reg == WORDS && buf_empty) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_VERDICT: state_reg <= ST_IDLE;
        ST_ABORT:   state_reg <= ST_IDLE;
        default:    state_reg <= ST_IDLE;
      endcase
    end
  end

  // latch the operation kind at the start of a command
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_thr_reg     <= 1'b0;
      op_verdict_reg <= 1'b0;
    end else if (take) begin
      op_thr_reg     <= features == FEAT_THRESH;
      op_verdict_reg <= features == FEAT_VERDICT;
    end
  end

  // storage step
  // thresholds are fetched, values are committed, while busy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nv_req_reg   <= 1'b0;
      nv_fetch_reg <= 1'b0;
    end else if (take && req_ok) begin
      nv_req_reg   <= 1'b1;
      nv_fetch_reg <= features == FEAT_THRESH;
    end else if (nv_ack) begin
      nv_req_reg   <= 1'b0;
      nv_fetch_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bsy_reg <= 1'b0;
      drq_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE:    bsy_reg <= take;
        ST_NV: begin
          if (nv_ack && !op_verdict_reg) begin
            drq_reg <= 1'b1;
            bsy_reg <= 1'b0;
          end
        end
        ST_STREAM: begin
          if (word_reg == WORDS && buf_empty) begin
            drq_reg <= 1'b0;
          end
        end
        ST_VERDICT: bsy_reg <= 1'b0;
        ST_ABORT:   bsy_reg <= 1'b0;
        default: begin
          bsy_reg <= 1'b0;
          drq_reg <= 1'b0;
        end
      endcase
    end
  end

  // interrupt: raised as busy drops, a raise beats a clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intrq_reg <= 1'b0;
    end else if ((state_reg == ST_NV && nv_ack && !op_verdict_reg) ||
                 state_reg == ST_VERDICT || state_reg == ST_ABORT) begin
      intrq_reg <= 1'b1;
    end else if (intrq_clr || take) begin
      intrq_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_reg  <= 1'b0;
      abrt_reg <= 1'b0;
    end else if (state_reg == ST_ABORT) begin
      err_reg  <= 1'b1;
      abrt_reg <= 1'b1;
    end else if (take) begin
      err_reg  <= 1'b0;
      abrt_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyl_we_reg <= 1'b0;
      cyl_lo_reg <= 8'h00;
      cyl_hi_reg <= 8'h00;
    end else begin
      cyl_we_reg <= state_reg == ST_NV && nv_ack && op_verdict_reg;
      if (state_reg == ST_NV && nv_ack && op_verdict_reg) begin
        cyl_lo_reg <= exceeded ? FAIL_LO : SIG_LO;
        cyl_hi_reg <= exceeded ? FAIL_HI : SIG_HI;
      end
    end
  end

  // structure walker: one 16-bit word per push
  assign gen_valid = state_reg == ST_STREAM && word_reg != WORDS;
  assign push      = gen_valid && gen_ready;
  assign ofs       = {word_reg[7:0], 1'b0};
  assign val_cur   = vals[slot_reg*8 +: 8];

  always_comb begin
    lo_byte = 8'h00;
    hi_byte = 8'h00;
    if (ofs < OFS_ENTRY) begin
      lo_byte = REV_LO;
      hi_byte = REV_HI;
    end else if (ofs < OFS_PAD) begin
      lo_byte = entry_byte(op_thr_reg, slot_reg, pos_reg, val_cur);
      hi_byte = entry_byte(op_thr_reg, slot_reg, pos_reg + 4'h1, val_cur);
    end else if (ofs == OFS_CAP && !op_thr_reg) begin
      lo_byte = {6'h00, CAP_AUTOSAVE, CAP_PRE_POWER};
    end
    if (ofs == OFS_LAST) begin
      hi_byte = 8'h00 - (sum_reg + lo_byte);
    end
  end

  // word counter and entry position; all region edges fall on even bytes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_reg <= 9'h000;
      slot_reg <= 5'h00;
      pos_reg  <= 4'h0;
    end else if (take) begin
      word_reg <= 9'h000;
      slot_reg <= 5'h00;
      pos_reg  <= 4'h0;
    end else if (push) begin
      word_reg <= word_reg + WORD_STEP;
      if (ofs >= OFS_ENTRY && ofs < OFS_PAD) begin
        if (pos_reg == POS_LAST) begin
          pos_reg  <= 4'h0;
          slot_reg <= slot_reg + 5'h01;
        end else begin
          pos_reg <= pos_reg + POS_STEP;
        end
      end
    end
  end

  // running sum of the bytes already sent
  // summing what is sent keeps the checksum right if values move mid-block
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_reg <= 8'h00;
    end else if (take) begin
      sum_reg <= 8'h00;
    end else if (push) begin
      sum_reg <= sum_reg + lo_byte + hi_byte;
    end
  end

  // lower byte on the low half
  word_buffer #(
    .W (16)
  ) u_buf (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (gen_valid),
    .in_ready  (gen_ready),
    .in_data   ({hi_byte, lo_byte}),
    .out_valid (data_valid),
    .out_ready (data_read),
    .out_data  (data_word),
    .empty     (buf_empty)
  );
endmodule
`default_nettype wire

// ### rtl/word_buffer.sv
// two-entry word buffer between the structure walker and the data register
`default_nettype none
module word_buffer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              empty
);
  logic [W-1:0] head_reg;
  logic [W-1:0] tail_reg;
  logic         head_v_reg;
  logic         tail_v_reg;
  logic         push;
  logic         pop;

  // ready only hangs on the tail flop, so no path from out_ready
  assign in_ready  = !tail_v_reg;
  assign push      = in_valid && !tail_v_reg;
  assign pop       = head_v_reg && out_ready;
  assign out_valid = head_v_reg;
  assign out_data  = head_reg;
  assign empty     = !head_v_reg && !tail_v_reg;

  // head slot: refilled from the tail first to keep word order
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      head_reg   <= '0;
      head_v_reg <= 1'b0;
    end else if (!head_v_reg || pop) begin
      if (tail_v_reg) begin
        head_reg   <= tail_reg;
        head_v_reg <= 1'b1;
      end else begin
        head_reg   <= in_data;
        head_v_reg <= push;
      end
    end
  end

  // tail slot: catches a word while the head is stalled
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tail_reg   <= '0;
      tail_v_reg <= 1'b0;
    end else if (tail_v_reg) begin
      tail_v_reg <= !pop;
    end else if (push && head_v_reg && !pop) begin
      tail_reg   <= in_data;
      tail_v_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire
